// ===== dv/cbs_mem_model.sv
// cbs_mem_model: memory and port decoders answering the sequencer
// assumes active-low strobes; unselected data changes every clock
`timescale 1ns/10ps
`default_nettype none
module cbs_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] bus_addr,
    input  wire logic        rd_n,
    input  wire logic        memory_request_n,
    input  wire logic        io_request_n,
    output logic      [7:0]  data_in
);
    logic [7:0] junk_q = 8'h00;
    always @(posedge clk) junk_q <= junk_q + 8'h5b;
    assign data_in = (!rd_n && !(memory_request_n && io_request_n)) ?
                     bus_addr[7:0] + bus_addr[15:8] + 8'h3c : junk_q;
endmodule : cbs_mem_model
`default_nettype wire

// ===== dv/cbs_sequencer_checker.sv
// cbs_sequencer_checker: timing assertions on the sequencer ports
// assumes one clock, rst synchronous active high
`timescale 1ns/10ps
`default_nettype none
module cbs_sequencer_checker
    import cbs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        start,
    input wire logic [15:0] pc,
    input wire logic [15:0] bus_addr,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        memory_request_n,
    input wire logic        io_request_n,
    input wire logic        opcode_lead_flag,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [3:0]  mcycle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_idle_all_high: assert property (rd_n && wr_n |-> memory_request_n && io_request_n)
        else $error("request strobe low in idle state");
    a_port_read_form: assert property (!io_request_n |-> !rd_n && wr_n && memory_request_n)
        else $error("port request without read");
    a_zero_page_high: assert property (!io_request_n && mcycle == 4'h4 |->
        bus_addr[15:8] == 8'h00)
        else $error("upper address not zero");
    a_mem_write_form: assert property (!wr_n |-> !memory_request_n && rd_n && io_request_n)
        else $error("write without memory request");
    a_lead_three_clk: assert property ($fell(opcode_lead_flag) |->
        (!opcode_lead_flag)[*3] ##1 opcode_lead_flag)
        else $error("lead flag width wrong");
    a_memory_request_n_three_clk: assert property ($fell(memory_request_n) |-> (!memory_request_n)[*3])
        else $error("memory cycle shorter than three clocks");
    a_step_write_addr: assert property ($fell(wr_n) && mcycle == 4'h8 |->
        bus_addr == $past(bus_addr, 2) && !$past(rd_n, 2))
        else $error("write back address differs from read");
    a_start_first_fetch: assert property (start && !busy |=>
        busy && mcycle == 4'h1 && !opcode_lead_flag && bus_addr == pc)
        else $error("first fetch not started");
    a_done_after_busy: assert property (done |-> !busy && mcycle == 4'h0 && $past(busy))
        else $error("done without finished instruction");
endmodule : cbs_sequencer_checker
bind cbs_sequencer cbs_sequencer_checker u_cbs_sequencer_checker (.clk, .rst, .start, .pc,
    .bus_addr, .rd_n, .wr_n, .memory_request_n, .io_request_n, .opcode_lead_flag, .busy, .done,
    .mcycle);
`default_nettype wire

// ===== dv/tb.sv
// tb: self-checking bench for the machine-cycle sequencer
// assumes cbs_mem_model on the bus and the checker bound to the design
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cbs_pkg::*;
    localparam logic [5:0] F1 = 6'h14, F2 = 6'h15, RD = 6'h17, WR = 6'h27, IO = 6'h1b, ID = 6'h3f;
    logic clk = 0, rst = 1, start = 0, cond_true = 0, count_nonzero = 0, pend = 0, jck = 0;
    logic rd_n, wr_n, memory_request_n, io_request_n, opcode_fetch_cycle_n, halt_n;
    logic opcode_lead_flag, busy, done;
    logic [15:0] pc = 0, index_reg = 0, pair_reg = 0, pointer_reg = 0, bus_addr, jump_target, jt;
    logic [7:0] accum = 0, data_in;
    logic [3:0] mcycle, mc;
    cbs_op_t op = CBS_OP_STEP_IDX_MEM;
    logic [26:0] exp_q[$];
    integer n_fail = 0, num_checks = 0, cycles = 0, seed = 32'h656d7a0f;
    cbs_sequencer u_cbs_sequencer (.clk, .rst, .start, .op, .cond_true, .count_nonzero, .pc,
        .index_reg, .pair_reg, .pointer_reg, .accum, .data_in, .bus_addr, .rd_n, .wr_n,
        .memory_request_n, .io_request_n, .opcode_fetch_cycle_n, .halt_n, .opcode_lead_flag,
        .busy, .done, .mcycle, .jump_target);
    cbs_mem_model u_cbs_mem_model (.clk, .bus_addr, .rd_n, .memory_request_n, .io_request_n,
        .data_in);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    function automatic logic [7:0] mdata(logic [15:0] a);
        return a[7:0] + a[15:8] + 8'h3c;
    endfunction : mdata
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic put(logic [5:0] s, logic [15:0] a);
        mc++;
        repeat ((s == ID) ? 1 : 3) exp_q.push_back({mc, s != ID, s, a});
    endtask : put
    task automatic fin();
        @(negedge clk);
        if (pend) begin
            chk("done and busy", 16'h2, {14'h0, done, busy});
            if (jck) chk("jump target", jt, jump_target);
        end
    endtask : fin
    task automatic run(cbs_op_t o);
        logic [15:0] a;
        logic [7:0] d;
        logic [15:0] want, seen;
        @(posedge clk);
        op <= o;
        start <= 1'b1;
        {pc, index_reg} <= $random(seed);
        {pair_reg, pointer_reg} <= $random(seed);
        {accum, cond_true, count_nonzero} <= 10'($random(seed));
        fin();
        @(posedge clk);
        op <= CBS_OP_STEP_IDX_MEM;
        exp_q.delete();
        {mc, jck, pend} = 6'h01;
        put(F1, pc);
        if (!(o inside {CBS_OP_PORT_IMM, CBS_OP_JUMP_ABSOLUTE_OP, CBS_OP_JUMP_COND}))
            put(F2, pc + 16'h1);
        case (o)
            CBS_OP_STEP_IDX_MEM: begin
                d = mdata(pc + 16'h2);
                a = index_reg + {{8{d[7]}}, d};
                put(RD, pc + 16'h2);
                put(ID, a);
                put(ID, a);
                put(RD, a);
                put(ID, a);
                put(WR, a);
            end
            CBS_OP_STEP_IDX_REG: put(ID, pc);
            CBS_OP_PORT_IMM: begin
                put(RD, pc + 16'h1);
                put(IO, {accum, mdata(pc + 16'h1)});
            end
            CBS_OP_ZERO_PAGE_PORT_READ_OP: begin
                put(RD, pc + 16'h2);
                put(IO, {8'h00, mdata(pc + 16'h2)});
            end
            CBS_OP_PORT_PAIR: put(IO, pair_reg);
            CBS_OP_REPEAT_PORT_READ_UP, CBS_OP_REPEAT_PORT_READ_DOWN: begin
                put(IO, pair_reg);
                put(WR, pointer_reg);
                if (count_nonzero) begin
                    put(ID, pc);
                    put(ID, pc);
                end
            end
            CBS_OP_JUMP_ABSOLUTE_OP, CBS_OP_JUMP_COND: begin
                put(RD, pc + 16'h1);
                jck = (o == CBS_OP_JUMP_ABSOLUTE_OP) || cond_true;
                if (jck) put(RD, pc + 16'h2);
                jt = {mdata(pc + 16'h2), mdata(pc + 16'h1)};
            end
            default: ;
        endcase
        foreach (exp_q[i]) begin
            @(negedge clk);
            want = {4'h0, exp_q[i][26:23], 2'h3, exp_q[i][21:16]};
            seen = {4'h0, mcycle, busy, halt_n, rd_n, wr_n, memory_request_n, io_request_n,
                opcode_fetch_cycle_n, opcode_lead_flag};
            chk("cycle strobes", want, seen);
            if (exp_q[i][22]) chk("address", exp_q[i][15:0], bus_addr);
            if (i == 0) begin
                @(posedge clk);
                start <= 1'b0;
            end
        end
        $display("test %s ended", o.name());
    endtask : run
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset strobes", 16'h3f, {10'h0, rd_n, wr_n, memory_request_n, io_request_n,
            opcode_fetch_cycle_n, opcode_lead_flag});
        chk("reset state", 16'h0, {10'h0, busy, done, mcycle});
        chk("reset address", 16'h0, bus_addr | jump_target);
        for (int r = 0; r < 3; r++)
            for (int k = 0; k < 10; k++)
                run(cbs_op_t'(k));
        @(posedge clk);
        fin();
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// ===== include/cbs_pkg.sv
// cbs_pkg: shared types and constants of the machine-cycle sequencer
// assumes a single clock domain; used by the sequencer, its checker and bench
package cbs_pkg;

    // instructions whose bus cycles are sequenced
    typedef enum logic [3:0] {
        CBS_OP_STEP_IDX_MEM,
        CBS_OP_STEP_IDX_REG,
        CBS_OP_PORT_IMM,
        CBS_OP_ZERO_PAGE_PORT_READ_OP,
        CBS_OP_PORT_PAIR,
        CBS_OP_REPEAT_PORT_READ_UP,
        CBS_OP_REPEAT_PORT_READ_DOWN,
        CBS_OP_JUMP_ABSOLUTE_OP,
        CBS_OP_JUMP_COND,
        CBS_OP_JUMP_IDX
    } cbs_op_t;

    // kind of the machine cycle in progress
    typedef enum logic [2:0] {
        CBS_K_END,
        CBS_K_FETCH1,
        CBS_K_FETCH2,
        CBS_K_OPERAND,
        CBS_K_MEM_READ,
        CBS_K_MEM_WRITE,
        CBS_K_IO_READ,
        CBS_K_IDLE
    } cbs_kind_t;

    // t-state counts: a bus cycle is t1..t3, an idle state one clock
    localparam logic [1:0] CBS_T_FIRST   = 2'h0;
    localparam logic [1:0] CBS_T_LAST    = 2'h2;
    localparam logic [3:0] CBS_MC_FIRST  = 4'h1;
    localparam logic [3:0] CBS_MC_NONE   = 4'h0;
    localparam logic [1:0] CBS_OFF_RST   = 2'h0;
    localparam logic [7:0] CBS_ZERO_PAGE = 8'h00;
    localparam logic [15:0] CBS_ADDR_RST = 16'h0000;
    localparam logic       CBS_STROBE_RST = 1'b1;

endpackage : cbs_pkg

// ===== src/cbs_sequencer.sv
// cbs_sequencer: machine-cycle sequencer for bus strobes and address
// assumes same-clock core logic gives start, op and register values
// Contract
// RQ1: indexed memory step: two fetches, displacement, two idles, read, idle, write in eighth
// RQ2: index register step: two opcode fetches then one idle with all strobes high
// RQ3: immediate port read: byte on low address, accumulator high, port request and read low
// RQ4: zero-page port read: fourth cycle reads port, upper address forced zero
// RQ5: pair port read: two fetches then port read at full pair address
// RQ6: repeat port read: port read, memory write at pointer, two idles while counter nonzero
// RQ7: absolute jump: fetch, then low and high target byte reads
// RQ8: conditional jump reads high target byte only when condition holds
// RQ9: indexed register jump: two fetches, lead flag low only in first
// RQ10: outside decoders answer only while their request strobe is low
`timescale 1ns/10ps
`default_nettype none
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire cbs_op_t     op,
    input  wire logic        cond_true,
    input  wire logic        count_nonzero,
    input  wire logic [15:0] pc,
    input  wire logic [15:0] index_reg,
    input  wire logic [15:0] pair_reg,
    input  wire logic [15:0] pointer_reg,
    input  wire logic [7:0]  accum,
    input  wire logic [7:0]  data_in,
    output logic      [15:0] bus_addr,
    output logic             rd_n,
    output logic             wr_n,
    output logic             memory_request_n,
    output logic             io_request_n,
    output logic             opcode_fetch_cycle_n,
    output logic             halt_n,
    output logic             opcode_lead_flag,
    output logic             busy,
    output logic             done,
    output logic      [3:0]  mcycle,
    output logic      [15:0] jump_target
);

    cbs_op_t     op_q,    op_d;
    cbs_kind_t   kind_q,  kind_d;
    logic [1:0]  t_q,     t_d;
    logic [3:0]  mc_q,    mc_d;
    logic [1:0]  off_q,   off_d;
    logic        ocnt_q,  ocnt_d;
    logic [7:0]  lo_q,    lo_d;
    logic [7:0]  hi_q,    hi_d;
    logic [15:0] addr_q,  addr_d;
    logic        rd_q,    rd_d;
    logic        wr_q,    wr_d;
    logic        memory_request_n_q,  memory_request_n_d;
    logic        ioreq_q, ioreq_d;
    logic        fetch_q, fetch_d;
    logic        lead_q,  lead_d;
    logic        busy_q,  busy_d;
    logic        done_q,  done_d;
    logic        halt_q;

    // cycle kind for each machine cycle of each instruction
    function automatic cbs_kind_t seq(input cbs_op_t o, input logic [3:0] m,
                                      input logic c, input logic nz);
        cbs_kind_t k;
        k = CBS_K_END;
        case (o)
            // RQ1 indexed memory steps
            CBS_OP_STEP_IDX_MEM: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    4'h3:    k = CBS_K_OPERAND;
                    4'h4:    k = CBS_K_IDLE;
                    4'h5:    k = CBS_K_IDLE;
                    4'h6:    k = CBS_K_MEM_READ;
                    4'h7:    k = CBS_K_IDLE;
                    4'h8:    k = CBS_K_MEM_WRITE;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ2 fetch, fetch, idle
            CBS_OP_STEP_IDX_REG: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    4'h3:    k = CBS_K_IDLE;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ3 port read in third cycle
            CBS_OP_PORT_IMM: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_OPERAND;
                    4'h3:    k = CBS_K_IO_READ;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ4 port read in fourth cycle
            CBS_OP_ZERO_PAGE_PORT_READ_OP: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    4'h3:    k = CBS_K_OPERAND;
                    4'h4:    k = CBS_K_IO_READ;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ5 port read after two fetches
            CBS_OP_PORT_PAIR: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    4'h3:    k = CBS_K_IO_READ;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ6 read port, write memory, idles while counting
            CBS_OP_REPEAT_PORT_READ_UP,
            CBS_OP_REPEAT_PORT_READ_DOWN: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    4'h3:    k = CBS_K_IO_READ;
                    4'h4:    k = CBS_K_MEM_WRITE;
                    4'h5:    k = nz ? CBS_K_IDLE : CBS_K_END;
                    4'h6:    k = nz ? CBS_K_IDLE : CBS_K_END;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ7 fetch and two target reads
            CBS_OP_JUMP_ABSOLUTE_OP: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_OPERAND;
                    4'h3:    k = CBS_K_OPERAND;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ8 high byte only if condition holds
            CBS_OP_JUMP_COND: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_OPERAND;
                    4'h3:    k = c ? CBS_K_OPERAND : CBS_K_END;
                    default: k = CBS_K_END;
                endcase
            end
            // RQ9 two fetches only
            CBS_OP_JUMP_IDX: begin
                case (m)
                    4'h1:    k = CBS_K_FETCH1;
                    4'h2:    k = CBS_K_FETCH2;
                    default: k = CBS_K_END;
                endcase
            end
            default: k = CBS_K_END;
        endcase
        return k;
    endfunction : seq

    // sequencing of machine cycles and t-states
    always_comb begin
        op_d   = op_q;
        kind_d = kind_q;
        t_d    = t_q;
        mc_d   = mc_q;
        off_d  = off_q;
        ocnt_d = ocnt_q;
        lo_d   = lo_q;
        hi_d   = hi_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (!busy_q) begin
            if (start) begin
                op_d   = op;
                kind_d = CBS_K_FETCH1;
                t_d    = CBS_T_FIRST;
                mc_d   = CBS_MC_FIRST;
                off_d  = CBS_OFF_RST;
                ocnt_d = 1'b0;
                busy_d = 1'b1;
            end
        end else if (kind_q == CBS_K_IDLE || t_q == CBS_T_LAST) begin
            if (kind_q == CBS_K_FETCH1 || kind_q == CBS_K_FETCH2 || kind_q == CBS_K_OPERAND) begin
                off_d = off_q + 2'h1;
            end
            if (kind_q == CBS_K_OPERAND) begin
                ocnt_d = 1'b1;
                if (ocnt_q) begin
                    hi_d = data_in;
                end else begin
                    lo_d = data_in;
                end
            end
            mc_d   = mc_q + 4'h1;
            t_d    = CBS_T_FIRST;
            kind_d = seq(op_q, mc_d, cond_true, count_nonzero);
            if (kind_d == CBS_K_END) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                mc_d   = CBS_MC_NONE;
            end
        end else begin
            t_d = t_q + 2'h1;
        end
    end

    // strobes and address for the cycle about to run
    always_comb begin
        addr_d  = addr_q;
        rd_d    = 1'b1;
        wr_d    = 1'b1;
        memory_request_n_d  = 1'b1;
        ioreq_d = 1'b1;
        fetch_d = 1'b1;
        lead_d  = 1'b1;
        case (kind_d)
            CBS_K_FETCH1: begin
                // RQ9 lead flag low in first fetch
                lead_d  = 1'b0;
                fetch_d = 1'b0;
                rd_d    = 1'b0;
                memory_request_n_d  = 1'b0;
                addr_d  = pc + {14'h0000, off_d};
            end
            CBS_K_FETCH2: begin
                // RQ2 second fetch also marks fetch cycle
                fetch_d = 1'b0;
                rd_d    = 1'b0;
                memory_request_n_d  = 1'b0;
                addr_d  = pc + {14'h0000, off_d};
            end
            CBS_K_OPERAND: begin
                rd_d   = 1'b0;
                memory_request_n_d = 1'b0;
                addr_d = pc + {14'h0000, off_d};
            end
            CBS_K_MEM_READ,
            CBS_K_MEM_WRITE: begin
                rd_d   = (kind_d != CBS_K_MEM_READ);
                wr_d   = (kind_d != CBS_K_MEM_WRITE);
                memory_request_n_d = 1'b0;
                // RQ1 index plus signed displacement
                if (op_d == CBS_OP_STEP_IDX_MEM) begin
                    addr_d = index_reg + {{8{lo_d[7]}}, lo_d};
                end else begin
                    // RQ6 write to pointer address
                    addr_d = pointer_reg;
                end
            end
            CBS_K_IO_READ: begin
                rd_d    = 1'b0;
                ioreq_d = 1'b0;
                if (op_d == CBS_OP_PORT_IMM) begin
                    // RQ3 accumulator high, port byte low
                    addr_d = {accum, lo_d};
                end else if (op_d == CBS_OP_ZERO_PAGE_PORT_READ_OP) begin
                    // RQ4 upper byte forced zero
                    addr_d = {CBS_ZERO_PAGE, lo_d};
                end else begin
                    // RQ5 full pair as port address
                    addr_d = pair_reg;
                end
            end
            default: begin
                addr_d = addr_q;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q    <= CBS_OP_STEP_IDX_REG;
            kind_q  <= CBS_K_END;
            t_q     <= CBS_T_FIRST;
            mc_q    <= CBS_MC_NONE;
            off_q   <= CBS_OFF_RST;
            ocnt_q  <= 1'b0;
            lo_q    <= 8'h00;
            hi_q    <= 8'h00;
            addr_q  <= CBS_ADDR_RST;
            rd_q    <= CBS_STROBE_RST;
            wr_q    <= CBS_STROBE_RST;
            memory_request_n_q  <= CBS_STROBE_RST;
            ioreq_q <= CBS_STROBE_RST;
            fetch_q <= CBS_STROBE_RST;
            lead_q  <= CBS_STROBE_RST;
            halt_q  <= CBS_STROBE_RST;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            op_q    <= op_d;
            kind_q  <= kind_d;
            t_q     <= t_d;
            mc_q    <= mc_d;
            off_q   <= off_d;
            ocnt_q  <= ocnt_d;
            lo_q    <= lo_d;
            hi_q    <= hi_d;
            addr_q  <= addr_d;
            rd_q    <= rd_d;
            wr_q    <= wr_d;
            memory_request_n_q  <= memory_request_n_d;
            ioreq_q <= ioreq_d;
            fetch_q <= fetch_d;
            lead_q  <= lead_d;
            halt_q  <= CBS_STROBE_RST;
            busy_q  <= busy_d;
            done_q  <= done_d;
        end
    end

    assign bus_addr             = addr_q;
    assign rd_n                 = rd_q;
    assign wr_n                 = wr_q;
    assign memory_request_n     = memory_request_n_q;
    assign io_request_n         = ioreq_q;
    assign opcode_fetch_cycle_n = fetch_q;
    assign halt_n               = halt_q;
    assign opcode_lead_flag     = lead_q;
    assign busy                 = busy_q;
    assign done                 = done_q;
    assign mcycle               = mc_q;
    assign jump_target          = {hi_q, lo_q};

endmodule : cbs_sequencer
`default_nettype wire
